// ===== include/an_adv_pkg.sv
// Package with offsets, field layouts and reset values of the advertisement registers.
package an_adv_pkg;
    localparam logic [4:0]  MMD_AN           = 5'h07;
    localparam logic [15:0] OFS_ADV_LOW      = 16'h0202;
    localparam logic [15:0] OFS_ADV_MIDDLE   = 16'h0203;
    localparam logic [15:0] OFS_ADV_HIGH     = 16'h0204;
    localparam logic [15:0] RST_ADV_LOW      = 16'h0001;
    localparam logic [15:0] RST_ADV_MIDDLE   = 16'h4000;
    localparam logic [15:0] RST_ADV_HIGH     = 16'h0000;
    localparam int          POS_MORE_PAGES   = 15;
    localparam int          POS_ACK          = 14;
    localparam int          POS_FAR_FAULT    = 13;
    localparam int          POS_ROLE_FORCED  = 12;
    localparam int          POS_FLOW_HI      = 11;
    localparam int          POS_FLOW_LO      = 10;
    localparam int          POS_LONG_REACH   = 14;
    localparam int          POS_ROLE_MASTER  = 4;
    localparam int          POS_HL_ABLE      = 13;
    localparam int          POS_HL_REQUEST   = 12;
    localparam logic [4:0]  SELECTOR_IEEE    = 5'h01;
    localparam logic [1:0]  RST_FLOW         = 2'h0;

    // Register access from the management frame decoder.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  mmd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    // Fields of the advertised base page as the negotiation engine sees them.
    typedef struct packed {
        logic       more_pages_wanted;
        logic       codeword_acknowledge;
        logic       far_fault;
        logic       role_forced;
        logic [1:0] flow_control_ability;
        logic [4:0] protocol_selector;
        logic       long_reach_ability;
        logic       role_master;
        logic       high_level_able;
        logic       high_level_request;
    } adv_fields_t;
endpackage

// ===== design/an_advertisement_regs.sv
// Base page advertisement register set of the single-pair PHY negotiation block.
//
// Summary of operation
// - Bit 15 low: writable next page request.
// - Bit 14 low: read-only codeword acknowledge flag.
// - Bit 13 low: writable remote fault, advertised.
// - Bit 12: role forced when one, else preferred.
// - Bits 11:10: pause ability, reset zero.
// - Selector bits 4:0 fixed read-only at one.
// - Middle bit 14: long reach ability, resets one.
// - Middle bit 4: role, strap reset value.
// - Role sent as nonce bit 4.
// - Reset values 0x0001, 0x4000, straps applied.
// - Registers 0x0202 to 0x0204 in device 0x07.
// - Resolve transmit level from ability and request.
`timescale 1ns/1ps
module an_advertisement_regs
    import an_adv_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire mgmt_req_t   req_in,
    output logic [15:0]      rdata_out,
    output logic             rhit_out,
    input  wire logic        codeword_received_in,
    input  wire logic        an_restart_in,
    input  wire logic        strap_master_in,
    input  wire logic        strap_high_level_in,
    input  wire logic        lp_high_level_able_in,
    input  wire logic        lp_high_level_request_in,
    output adv_fields_t      adv_out,
    output logic [47:0]      base_page_out,
    output logic [4:0]       nonce_role_out,
    output logic             tx_level_high_out
);

    // Stored fields of the low register; bit 14 is set by the engine only.
    logic        more_pages_wanted;
    logic        codeword_acknowledge;
    logic        far_fault;
    logic        role_forced;
    logic [1:0]  flow_control_ability;

    // Stored fields of the middle and high registers.
    logic        long_reach_ability;
    logic        role_master;
    logic        high_level_able;
    logic        high_level_request;

    // Strap load strobe and decoded host writes, one per register.
    logic        strap_load;
    logic        low_write;
    logic        middle_write;
    logic        high_write;

    // Assembled register words and the selected read answer.
    logic [15:0] adv_base_low;
    logic [15:0] adv_base_middle;
    logic [15:0] adv_base_high;
    logic [16:0] read_result;

    // Register words are assembled by functions so that the read path and the
    // base page always show the same bits.

    // True when the request addresses the given register of this device.
    function automatic logic hit(input mgmt_req_t r, input logic [15:0] ofs);
        hit = (r.mmd == MMD_AN) && (r.addr == ofs);
    endfunction

    // True when the request is a write to the given register.
    function automatic logic write_hit(input mgmt_req_t r, input logic [15:0] ofs);
        write_hit = r.wr && hit(r, ofs);
    endfunction

    // Builds the low register word; bits 9:5 stay zero and the selector is fixed.
    function automatic logic [15:0] pack_low(
        input logic       mp,
        input logic       ack,
        input logic       ff,
        input logic       rf,
        input logic [1:0] fc
    );
        pack_low = 16'h0000;
        pack_low[POS_MORE_PAGES]          = mp;
        pack_low[POS_ACK]                 = ack;
        pack_low[POS_FAR_FAULT]           = ff;
        pack_low[POS_ROLE_FORCED]         = rf;
        pack_low[POS_FLOW_HI:POS_FLOW_LO] = fc;
        pack_low[4:0]                     = SELECTOR_IEEE;
    endfunction

    // Builds the middle register word; all other bits read as zero.
    function automatic logic [15:0] pack_middle(
        input logic lr,
        input logic rm
    );
        pack_middle = 16'h0000;
        pack_middle[POS_LONG_REACH]  = lr;
        pack_middle[POS_ROLE_MASTER] = rm;
    endfunction

    // Builds the high register word; all other bits read as zero.
    function automatic logic [15:0] pack_high(
        input logic able,
        input logic request
    );
        pack_high = 16'h0000;
        pack_high[POS_HL_ABLE]    = able;
        pack_high[POS_HL_REQUEST] = request;
    endfunction

    // A read and a write in one cycle return the value held before the write.
    // Picks the addressed word for a read; hit flag in bit 16, zero on a miss.
    function automatic logic [16:0] read_select(
        input mgmt_req_t   r,
        input logic [15:0] low,
        input logic [15:0] middle,
        input logic [15:0] high
    );
        if (!r.rd) begin
            read_select = 17'h00000;
        end else if (hit(r, OFS_ADV_LOW)) begin
            read_select = {1'b1, low};
        end else if (hit(r, OFS_ADV_MIDDLE)) begin
            read_select = {1'b1, middle};
        end else if (hit(r, OFS_ADV_HIGH)) begin
            read_select = {1'b1, high};
        end else begin
            read_select = 17'h00000;
        end
    endfunction

    // Low level unless both sides are able; then high if either side asks.
    function automatic logic resolve_level(
        input logic own_able,
        input logic own_request,
        input logic far_able,
        input logic far_request
    );
        resolve_level = own_able && far_able && (own_request || far_request);
    endfunction

    // Straps are caught by a clocked load in the first cycle after reset release.
    // A host write in that same cycle to a strapped bit is overridden by the strap.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strap_load <= 1'b1;
        end else begin
            strap_load <= 1'b0;
        end
    end

    // Write strobes for the three registers; other addresses and devices are refused.
    always_comb begin
        low_write    = write_hit(req_in, OFS_ADV_LOW);
        middle_write = write_hit(req_in, OFS_ADV_MIDDLE);
        high_write   = write_hit(req_in, OFS_ADV_HIGH);
    end

    // Next page request, sent to the partner through the base page.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            more_pages_wanted <= RST_ADV_LOW[POS_MORE_PAGES];
        end else if (low_write) begin
            more_pages_wanted <= req_in.wdata[POS_MORE_PAGES];
        end
    end

    // Remote fault flag, sent to the partner through the base page.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            far_fault <= RST_ADV_LOW[POS_FAR_FAULT];
        end else if (low_write) begin
            far_fault <= req_in.wdata[POS_FAR_FAULT];
        end
    end

    // Zero makes the advertised role a preference, one makes it forced.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            role_forced <= RST_ADV_LOW[POS_ROLE_FORCED];
        end else if (low_write) begin
            role_forced <= req_in.wdata[POS_ROLE_FORCED];
        end
    end

    // Pause ability field, cleared by reset.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flow_control_ability <= RST_FLOW;
        end else if (low_write) begin
            flow_control_ability <= req_in.wdata[POS_FLOW_HI:POS_FLOW_LO];
        end
    end

    // Acknowledge is set by the engine on codeword reception and cleared on restart.
    // A codeword arriving with a restart in the same cycle leaves it set.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            codeword_acknowledge <= RST_ADV_LOW[POS_ACK];
        end else if (codeword_received_in) begin
            codeword_acknowledge <= 1'b1;
        end else if (an_restart_in) begin
            codeword_acknowledge <= 1'b0;
        end
    end

    // The long reach bit is not strapped and keeps its printed reset value.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            long_reach_ability <= RST_ADV_MIDDLE[POS_LONG_REACH];
        end else if (middle_write) begin
            long_reach_ability <= req_in.wdata[POS_LONG_REACH];
        end
    end

    // The role takes the strap level once, then follows host writes.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            role_master <= RST_ADV_MIDDLE[POS_ROLE_MASTER];
        end else if (strap_load) begin
            role_master <= strap_master_in;
        end else if (middle_write) begin
            role_master <= req_in.wdata[POS_ROLE_MASTER];
        end
    end

    // Both transmit level bits start from the same strap pin.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            high_level_able <= RST_ADV_HIGH[POS_HL_ABLE];
        end else if (strap_load) begin
            high_level_able <= strap_high_level_in;
        end else if (high_write) begin
            high_level_able <= req_in.wdata[POS_HL_ABLE];
        end
    end

    // The level request bit, also strapped at release.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            high_level_request <= RST_ADV_HIGH[POS_HL_REQUEST];
        end else if (strap_load) begin
            high_level_request <= strap_high_level_in;
        end else if (high_write) begin
            high_level_request <= req_in.wdata[POS_HL_REQUEST];
        end
    end

    // Register words are rebuilt every cycle from the stored fields.
    always_comb begin
        adv_base_low    = pack_low(more_pages_wanted, codeword_acknowledge, far_fault,
                                   role_forced, flow_control_ability);
        adv_base_middle = pack_middle(long_reach_ability, role_master);
        adv_base_high   = pack_high(high_level_able, high_level_request);
        read_result     = read_select(req_in, adv_base_low, adv_base_middle, adv_base_high);
    end

    // Read data is registered and stands for one cycle; it is zero otherwise.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= read_result[15:0];
        end
    end

    // Read hit flag, set only the cycle after a read of a mapped register.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rhit_out <= 1'b0;
        end else begin
            rhit_out <= read_result[16];
        end
    end

    // Field view for the negotiation engine; the selector is a constant.
    // Nothing here is registered again, so it follows the flops directly.
    always_comb begin
        adv_out.more_pages_wanted    = more_pages_wanted;
        adv_out.codeword_acknowledge = codeword_acknowledge;
        adv_out.far_fault            = far_fault;
        adv_out.role_forced          = role_forced;
        adv_out.flow_control_ability = flow_control_ability;
        adv_out.protocol_selector    = SELECTOR_IEEE;
        adv_out.long_reach_ability   = long_reach_ability;
        adv_out.role_master          = role_master;
        adv_out.high_level_able      = high_level_able;
        adv_out.high_level_request   = high_level_request;
    end

    // The base page places the high word on top and the low word at the bottom.
    assign base_page_out  = {adv_base_high, adv_base_middle, adv_base_low};

    // Only bit 4 of the nonce field carries the role; the rest is zero here.
    assign nonce_role_out = {role_master, 4'h0};

    // Level resolution uses our advertised bits and the partner's bits.
    assign tx_level_high_out = resolve_level(high_level_able, high_level_request,
        lp_high_level_able_in, lp_high_level_request_in);

endmodule

// ===== dv/an_adv_monitor.sv
// Assertion checker for the advertisement register set.
`timescale 1ns/1ps
module an_adv_monitor
    import an_adv_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        nrst_in,
    input wire mgmt_req_t   req_in,
    input wire logic [15:0] rdata_out,
    input wire logic        rhit_out,
    input wire logic        codeword_received_in,
    input wire logic        lp_high_level_able_in,
    input wire logic        lp_high_level_request_in,
    input wire logic [47:0] base_page_out,
    input wire logic [4:0]  nonce_role_out,
    input wire logic        tx_level_high_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    sequence s_low;
        req_in.mmd == MMD_AN && req_in.addr == OFS_ADV_LOW;
    endsequence
    property p_rd_hit;
        req_in.rd ##0 s_low |=> rhit_out && rdata_out == $past(base_page_out[15:0]);
    endproperty
    a_rd_hit: assert property (p_rd_hit) else $error("low read wrong");
    property p_miss;
        req_in.rd && req_in.mmd != MMD_AN |=> !rhit_out && rdata_out == 16'h0000;
    endproperty
    a_miss: assert property (p_miss) else $error("foreign read answered");
    property p_wr_low;
        req_in.wr ##0 s_low |=> base_page_out[15] == $past(req_in.wdata[15])
            && base_page_out[13:10] == $past(req_in.wdata[13:10]);
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("low write lost");
    property p_const;
        base_page_out[4:0] == SELECTOR_IEEE && base_page_out[9:5] == 5'h00;
    endproperty
    a_const: assert property (p_const) else $error("selector wrong");
    property p_ack;
        codeword_received_in |=> base_page_out[14];
    endproperty
    a_ack: assert property (p_ack) else $error("ack not set");
    property p_nonce;
        nonce_role_out == {base_page_out[20], 4'h0};
    endproperty
    a_nonce: assert property (p_nonce) else $error("nonce role wrong");
    property p_lvl;
        tx_level_high_out == (base_page_out[45] && lp_high_level_able_in
            && (base_page_out[44] || lp_high_level_request_in));
    endproperty
    a_lvl: assert property (p_lvl) else $error("level wrong");
    property p_rsv;
        base_page_out[47:46] == 2'h0 && base_page_out[43:32] == 12'h000
            && base_page_out[31] == 1'b0 && base_page_out[19:16] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
endmodule

// ===== dv/mgmt_host.sv
// Management host model issuing register frames.
`timescale 1ns/1ps
module mgmt_host
    import an_adv_pkg::*;
(
    input  wire logic        clk_sys_in,
    output mgmt_req_t        req_out,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rhit_in
);
    initial req_out = '0;
    task automatic access(input logic w, input logic [4:0] m, input logic [15:0] a,
                          input logic [15:0] wd, output logic [16:0] got);
        @(posedge clk_sys_in);
        #1 req_out = '{rd: !w, wr: w, mmd: m, addr: a, wdata: wd};
        @(posedge clk_sys_in);
        #1 got = {rhit_in, rdata_in};
        // Released lines do not keep their last value.
        req_out = '{rd: 1'b0, wr: 1'b0, mmd: ~m, addr: ~a, wdata: ~wd};
    endtask
endmodule

// ===== dv/an_advertisement_regs_bench.sv
// Self-checking testbench for the advertisement register set.
`timescale 1ns/1ps
module an_advertisement_regs_bench;
    import an_adv_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        cw = 1'b0;
    logic        restart = 1'b0;
    logic [1:0]  lp = 2'h0;
    logic        strap_m = 1'b1;
    logic        strap_h = 1'b1;
    adv_fields_t adv;
    mgmt_req_t   req;
    logic [15:0] rdata;
    logic        rhit;
    logic [4:0]  nonce;
    logic        lvl;
    int          mismatches = 0;
    int          samples_checked = 0;
    localparam logic [15:0] HI[5] = '{16'h3000, 16'h2000, 16'h2000, 16'h1000, 16'h3000};
    localparam logic [2:0]  LV[5] = '{3'h5, 3'h4, 3'h7, 3'h2, 3'h2};
    an_advertisement_regs u_dut(.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req),
        .rdata_out(rdata), .rhit_out(rhit), .codeword_received_in(cw),
        .an_restart_in(restart), .strap_master_in(strap_m), .strap_high_level_in(strap_h),
        .lp_high_level_able_in(lp[1]), .lp_high_level_request_in(lp[0]), .adv_out(adv),
        .base_page_out(), .nonce_role_out(nonce), .tx_level_high_out(lvl));
    mgmt_host u_host(.clk_sys_in(clk_sys_in), .req_out(req), .rdata_in(rdata), .rhit_in(rhit));
    task automatic check(input string n, input logic [16:0] e, input logic [16:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [4:0] m, input logic [15:0] a, input logic [16:0] e);
        logic [16:0] g;
        u_host.access(1'b0, m, a, 16'h0000, g);
        check("read", e, g);
    endtask
    task automatic wr(input logic [4:0] m, input logic [15:0] a, input logic [15:0] d);
        logic [16:0] g;
        u_host.access(1'b1, m, a, d, g);
    endtask
    task automatic end_sim;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #20 clk_sys_in = ~clk_sys_in;
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk_sys_in);
        #1 nrst_in = 1'b1;
        rd(MMD_AN, OFS_ADV_LOW, {1'b1, RST_ADV_LOW});
        rd(MMD_AN, OFS_ADV_MIDDLE, 17'h14010);
        rd(MMD_AN, OFS_ADV_HIGH, 17'h13000);
        wr(MMD_AN, OFS_ADV_LOW, 16'hffff);
        rd(MMD_AN, OFS_ADV_LOW, 17'h1bc01);
        wr(MMD_AN, OFS_ADV_MIDDLE, 16'h0000);
        rd(MMD_AN, OFS_ADV_MIDDLE, 17'h10000);
        check("nonce", 17'h0, {12'h0, nonce});
        wr(MMD_AN, OFS_ADV_MIDDLE, 16'hffff);
        rd(MMD_AN, OFS_ADV_MIDDLE, 17'h14010);
        check("nonce", 17'h10, {12'h0, nonce});
        wr(MMD_AN, OFS_ADV_HIGH, 16'hffff);
        rd(MMD_AN, OFS_ADV_HIGH, 17'h13000);
        for (int i = 0; i < 5; i++) begin
            lp = LV[i][2:1];
            wr(MMD_AN, OFS_ADV_HIGH, HI[i]);
            check("level", {16'h0, LV[i][0]}, {16'h0, lvl});
        end
        wr(5'h03, OFS_ADV_LOW, 16'h0000);
        rd(5'h03, OFS_ADV_LOW, 17'h0);
        rd(MMD_AN, 16'h0205, 17'h0);
        cw = 1'b1;
        @(posedge clk_sys_in);
        #1 cw = 1'b0;
        rd(MMD_AN, OFS_ADV_LOW, 17'h1fc01);
        restart = 1'b1;
        @(posedge clk_sys_in);
        #1 restart = 1'b0;
        rd(MMD_AN, OFS_ADV_LOW, 17'h1bc01);
        cw = 1'b1;
        restart = 1'b1;
        @(posedge clk_sys_in);
        #1 cw = 1'b0;
        restart = 1'b0;
        rd(MMD_AN, OFS_ADV_LOW, 17'h1fc01);
        check("fields", {2'h0, 4'hf, 2'h3, SELECTOR_IEEE, 4'hf}, {2'h0, adv});
        strap_m = 1'b0;
        strap_h = 1'b0;
        nrst_in = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1 nrst_in = 1'b1;
        rd(MMD_AN, OFS_ADV_LOW, {1'b1, RST_ADV_LOW});
        rd(MMD_AN, OFS_ADV_MIDDLE, {1'b1, RST_ADV_MIDDLE});
        rd(MMD_AN, OFS_ADV_HIGH, {1'b1, RST_ADV_HIGH});
        check("role", 17'h0, {12'h0, nonce});
        end_sim();
    end
endmodule
bind an_advertisement_regs an_adv_monitor u_mon(.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .req_in(req_in), .rdata_out(rdata_out), .rhit_out(rhit_out),
    .codeword_received_in(codeword_received_in), .lp_high_level_able_in(lp_high_level_able_in),
    .lp_high_level_request_in(lp_high_level_request_in), .base_page_out(base_page_out),
    .nonce_role_out(nonce_role_out), .tx_level_high_out(tx_level_high_out));
